// ===== shared/timer_pkg.sv
// constants, register map and types shared by the timer block
package timer_pkg;
  localparam int NUM_CH = 6;
  localparam int CH_STRIDE = 3;
  // word indexes; byte address is four times the index
  localparam logic [5:0] IDX_STATUS = 6'h20;
  localparam logic [5:0] IDX_ROUTE = 6'h21;
  localparam logic [5:0] IDX_CNT_H = 6'h22;
  localparam logic [5:0] IDX_CNT_L = 6'h23;
  localparam logic [5:0] IDX_MOD_H = 6'h24;
  localparam logic [5:0] IDX_MOD_L = 6'h25;
  localparam logic [5:0] IDX_CH0 = 6'h26;
  localparam logic [5:0] IDX_CH1 = 6'h29;
  localparam logic [5:0] IDX_CH2 = 6'h2c;
  // status/control bits
  localparam int ST_FLAG = 7;
  localparam int ST_IRQ_EN = 6;
  localparam int ST_HALT = 5;
  localparam int ST_CLR = 4;
  // channel control bits
  localparam int CH_FLAG = 7;
  localparam int CH_IE = 6;
  localparam int CH_MSB = 5;
  localparam int CH_MSA = 4;
  localparam int CH_ELS_HI = 3;
  localparam int CH_ELS_LO = 2;
  localparam int CH_TOV = 1;
  localparam int CH_MAX = 0;
  localparam logic [7:0] CH_WMASK_EVEN = 8'h7f;
  localparam logic [7:0] CH_WMASK_ODD = 8'h5f;
  localparam logic [7:0] CH_RESET = 8'h00;
  localparam logic [15:0] MOD_RESET = 16'hffff;
  localparam logic [2:0] PS_RESET = 3'h0;
  localparam logic [2:0] PS_EXT = 3'h7;
  typedef enum logic [1:0] {
    MODE_PORT = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_COMPARE = 2'b10
  } chan_mode_e;
endpackage

// ===== shared/chan_if.sv
// link between the timer core and one capture/compare channel
interface chan_if;
  logic [15:0] count;
  logic [15:0] value;
  logic [7:0] ctl;
  logic tick;
  logic wrap;
  logic hold;
  logic disable_ch;
  logic pin_in;
  logic event_pulse;
  logic capture;
  logic pin_out;
  logic pin_oe;
  modport core (output count, value, ctl, tick, wrap, hold, disable_ch,
    pin_in, input event_pulse, capture, pin_out, pin_oe);
  modport unit (input count, value, ctl, tick, wrap, hold, disable_ch,
    pin_in, output event_pulse, capture, pin_out, pin_oe);
endinterface

// ===== rtl/channel_unit.sv
// one capture/compare channel: mode decode, edge detect, output pin
module channel_unit (
  input wire logic clk,
  input wire logic reset_n,
  chan_if.unit ch
);
  timer_pkg::chan_mode_e mode;
  logic [1:0] els;
  logic pin_d_r;
  logic max_r;
  logic rise;
  logic fall;
  logic cmp_hit;

  assign els = {ch.ctl[timer_pkg::CH_ELS_HI], ch.ctl[timer_pkg::CH_ELS_LO]};

  always_comb begin
    if (els == 2'b00 || ch.disable_ch) begin
      mode = timer_pkg::MODE_PORT;
    end else if (ch.ctl[timer_pkg::CH_MSB] || ch.ctl[timer_pkg::CH_MSA]) begin
      mode = timer_pkg::MODE_COMPARE;
    end else begin
      mode = timer_pkg::MODE_CAPTURE;
    end
  end

  assign rise = ch.pin_in & ~pin_d_r;
  assign fall = ~ch.pin_in & pin_d_r;
  // capture on the selected edge(s)
  assign ch.capture = (mode == timer_pkg::MODE_CAPTURE) & ~ch.hold &
    ((els[0] & rise) | (els[1] & fall));
  assign cmp_hit = (mode == timer_pkg::MODE_COMPARE) & ~ch.hold & ch.tick &
    (ch.count == ch.value);
  assign ch.event_pulse = ch.capture | cmp_hit;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_d_r <= 1'b0;
    end else begin
      pin_d_r <= ch.pin_in;
    end
  end

  // full-duty request only sampled at the period boundary
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      max_r <= 1'b0;
    end else if (ch.wrap) begin
      max_r <= ch.ctl[timer_pkg::CH_MAX];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ch.pin_out <= 1'b0;
      ch.pin_oe <= 1'b0;
    end else begin
      ch.pin_oe <= (mode == timer_pkg::MODE_COMPARE);
      case (mode)
        timer_pkg::MODE_PORT: begin
          ch.pin_out <= ~ch.ctl[timer_pkg::CH_MSA]; // preset level
        end
        timer_pkg::MODE_COMPARE: begin
          if (max_r && !ch.ctl[timer_pkg::CH_TOV]) begin
            ch.pin_out <= (els == 2'b10);
          end else if (ch.wrap && ch.ctl[timer_pkg::CH_TOV]) begin
            ch.pin_out <= ~ch.pin_out; // overflow wins
          end else if (cmp_hit) begin
            case (els)
              2'b01: ch.pin_out <= ~ch.pin_out;
              2'b10: ch.pin_out <= 1'b0;
              2'b11: ch.pin_out <= 1'b1;
              default: ch.pin_out <= ch.pin_out;
            endcase
          end
        end
        default: begin
          ch.pin_out <= ch.pin_out;
        end
      endcase
    end
  end
endmodule

// ===== rtl/timer_counter_control.sv
// timer core: APB registers, prescaler, 16-bit counter, six channels
//
// Register access over APB was decided locally.
module timer_counter_control #(
  parameter int NUM_CH = timer_pkg::NUM_CH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_clock_pin,
  output logic ext_clk_input_force,
  input wire logic [NUM_CH-1:0] ch_pin_in,
  output logic [NUM_CH-1:0] ch_pin_out,
  output logic [NUM_CH-1:0] ch_pin_oe,
  output logic overflow_irq,
  output logic [NUM_CH-1:0] ch_irq,
  output logic [NUM_CH-1:0] ch_dma_req
);
  // channel register index: kind 0 control, 1 value high, 2 value low
  function automatic logic [5:0] ch_index(input int k, input int kind);
    ch_index = timer_pkg::IDX_CH0 + 6'(timer_pkg::CH_STRIDE * k + kind);
  endfunction

  // mask of prescaler bits that must all be one for a tick
  function automatic logic [5:0] div_mask(input logic [2:0] sel);
    div_mask = 6'((7'h01 << sel) - 7'h01);
  endfunction

  logic [5:0] idx;
  logic mapped;
  logic setup;
  logic rd_go;
  logic wr_go;
  logic [7:0] rd_data;
  logic [7:0] wd;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  logic flag_r;
  logic irq_en_r;
  logic halt_r;
  logic [2:0] ps_r;
  logic flag_arm_r;
  logic irq_r;
  logic [NUM_CH-1:0] route_r;
  logic [15:0] count_r;
  logic [5:0] pre_r;
  logic [7:0] low_buf_r;
  logic low_latched_r;
  logic [15:0] mod_r;
  logic mod_inhibit_r;
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_d_r;
  logic ext_force_r;

  logic clr_cmd;
  logic tick;
  logic wrap;
  logic [7:0] ctl_rd [NUM_CH];
  logic [15:0] val_rd [NUM_CH];

  chan_if chif [NUM_CH] ();

  assign idx = paddr[7:2];
  assign setup = psel & ~penable & ~pready_r;
  assign wd = pwdata[7:0];

  always_comb begin
    mapped = (paddr[1:0] == 2'b00) &&
      (idx >= timer_pkg::IDX_STATUS) && (idx <= ch_index(NUM_CH - 1, 2));
  end

  assign rd_go = setup & ~pwrite & mapped;
  assign wr_go = psel & penable & pready_r & pwrite & mapped & pstrb[0];

  // read mux; reserved bits and undefined positions read zero
  always_comb begin
    rd_data = 8'h00;
    case (idx)
      timer_pkg::IDX_STATUS: begin
        rd_data[timer_pkg::ST_FLAG] = flag_r;
        rd_data[timer_pkg::ST_IRQ_EN] = irq_en_r;
        rd_data[timer_pkg::ST_HALT] = halt_r;
        rd_data[2:0] = ps_r; // clear bit reads zero
      end
      timer_pkg::IDX_ROUTE: rd_data = 8'(route_r);
      timer_pkg::IDX_CNT_H: rd_data = count_r[15:8];
      timer_pkg::IDX_CNT_L: begin
        rd_data = low_latched_r ? low_buf_r : count_r[7:0];
      end
      timer_pkg::IDX_MOD_H: rd_data = mod_r[15:8];
      timer_pkg::IDX_MOD_L: rd_data = mod_r[7:0];
      default: begin
        for (int k = 0; k < NUM_CH; k++) begin
          if (idx == ch_index(k, 0)) rd_data = ctl_rd[k];
          if (idx == ch_index(k, 1)) rd_data = val_rd[k][15:8];
          if (idx == ch_index(k, 2)) rd_data = val_rd[k][7:0];
        end
      end
    endcase
  end

  // APB slave: answer in the cycle after setup, no further waits
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      pready_r <= 1'b1;
      pslverr_r <= ~mapped;
      prdata_r <= (pwrite || !mapped) ? 32'h0000_0000 : {24'h000000, rd_data};
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  // status/control register
  assign clr_cmd = wr_go & (idx == timer_pkg::IDX_STATUS) &
    wd[timer_pkg::ST_CLR]; // write-only pulse, never stored

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_en_r <= 1'b0;
      halt_r <= 1'b1;
      ps_r <= timer_pkg::PS_RESET;
    end else if (wr_go && idx == timer_pkg::IDX_STATUS) begin
      irq_en_r <= wd[timer_pkg::ST_IRQ_EN];
      halt_r <= wd[timer_pkg::ST_HALT];
      ps_r <= wd[2:0];
    end
  end

  // overflow flag: set wins over clear, clear needs a prior armed read
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flag_r <= 1'b0;
      flag_arm_r <= 1'b0;
    end else begin
      if (wrap && !mod_inhibit_r) begin
        flag_r <= 1'b1;
        flag_arm_r <= 1'b0; // a new overflow voids the pending read
      end else if (rd_go && idx == timer_pkg::IDX_STATUS && flag_r) begin
        flag_arm_r <= 1'b1;
      end else if (wr_go && idx == timer_pkg::IDX_STATUS) begin
        if (flag_arm_r && !wd[timer_pkg::ST_FLAG]) begin
          flag_r <= 1'b0;
        end
        flag_arm_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= flag_r & irq_en_r & ~mod_inhibit_r;
    end
  end
  assign overflow_irq = irq_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      route_r <= '0;
    end else if (wr_go && idx == timer_pkg::IDX_ROUTE) begin
      route_r <= wd[NUM_CH-1:0];
    end
  end

  // external pin: synchronise and count rising edges
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_d_r <= 1'b0;
      ext_force_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_count_clock_pin;
      ext_s2_r <= ext_s1_r;
      ext_d_r <= ext_s2_r;
      ext_force_r <= (ps_r == timer_pkg::PS_EXT);
    end
  end
  assign ext_clk_input_force = ext_force_r;

  // counter tick from divided bus clock or pin edge
  always_comb begin
    if (ps_r == timer_pkg::PS_EXT) begin
      tick = ext_s2_r & ~ext_d_r;
    end else begin
      tick = ((pre_r & div_mask(ps_r)) == div_mask(ps_r));
    end
  end

  assign wrap = ~halt_r & ~clr_cmd & tick & (count_r == mod_r);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pre_r <= 6'h00;
    end else if (clr_cmd) begin
      pre_r <= 6'h00;
    end else if (!halt_r) begin
      pre_r <= pre_r + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_r <= 16'h0000;
    end else if (clr_cmd) begin
      count_r <= 16'h0000;
    end else if (!halt_r && tick) begin
      count_r <= wrap ? 16'h0000 : count_r + 16'h0001;
    end
  end

  // coherent 16-bit read: high read latches low byte
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      low_buf_r <= 8'h00;
      low_latched_r <= 1'b0;
    end else if (rd_go && idx == timer_pkg::IDX_CNT_H && !low_latched_r) begin
      low_buf_r <= count_r[7:0];
      low_latched_r <= 1'b1;
    end else if (rd_go && idx == timer_pkg::IDX_CNT_L) begin
      low_latched_r <= 1'b0;
    end
  end

  // wrap limit; high write blocks flag until low write
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mod_r <= timer_pkg::MOD_RESET;
      mod_inhibit_r <= 1'b0;
    end else if (wr_go && idx == timer_pkg::IDX_MOD_H) begin
      mod_r[15:8] <= wd;
      mod_inhibit_r <= 1'b1;
    end else if (wr_go && idx == timer_pkg::IDX_MOD_L) begin
      mod_r[7:0] <= wd;
      mod_inhibit_r <= 1'b0;
    end
  end

  for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
    localparam logic [7:0] WMASK = (k % 2 == 1) ?
      timer_pkg::CH_WMASK_ODD : timer_pkg::CH_WMASK_EVEN;
    logic [7:0] ctl_r;
    logic [15:0] val_r;
    logic flag_r;
    logic arm_r;
    logic hold_r;
    logic irq_r;
    logic dma_r;
    logic dma_mode;
    logic low_access;
    logic capture_mode;

    assign dma_mode = ctl_r[timer_pkg::CH_IE] & route_r[k];
    assign capture_mode = ~ctl_r[timer_pkg::CH_MSB] & ~ctl_r[timer_pkg::CH_MSA];
    assign low_access = (rd_go | wr_go) & (idx == ch_index(k, 2));

    assign chif[k].count = count_r;
    assign chif[k].value = val_r;
    assign chif[k].ctl = ctl_r;
    assign chif[k].tick = ~halt_r & tick;
    assign chif[k].wrap = wrap;
    assign chif[k].hold = hold_r;
    assign chif[k].pin_in = ch_pin_in[k];
    if (k % 2 == 1) begin : g_odd
      // odd channel gives way to its buffered even partner
      assign chif[k].disable_ch = g_ch[k-1].ctl_r[timer_pkg::CH_MSB];
    end else begin : g_even
      assign chif[k].disable_ch = 1'b0;
    end

    channel_unit u_unit (
      .clk(clk),
      .reset_n(reset_n),
      .ch(chif[k])
    );

    always_ff @(posedge clk) begin
      if (!reset_n) begin
        ctl_r <= timer_pkg::CH_RESET;
      end else if (wr_go && idx == ch_index(k, 0)) begin
        ctl_r <= wd & WMASK;
      end
    end

    always_ff @(posedge clk) begin
      if (!reset_n) begin
        val_r <= 16'h0000;
      end else if (chif[k].capture) begin
        val_r <= count_r;
      end else if (wr_go && idx == ch_index(k, 1)) begin
        val_r[15:8] <= wd;
      end else if (wr_go && idx == ch_index(k, 2)) begin
        val_r[7:0] <= wd;
      end
    end

    // high byte read holds capture, high byte write holds compare, until low byte access
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        hold_r <= 1'b0;
      end else if (idx == ch_index(k, 1) &&
                   ((rd_go && capture_mode) || (wr_go && !capture_mode))) begin
        hold_r <= 1'b1;
      end else if (low_access) begin
        hold_r <= 1'b0;
      end
    end

    // channel flag: set wins; DMA mode clears on low access
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        flag_r <= 1'b0;
        arm_r <= 1'b0;
      end else if (chif[k].event_pulse) begin
        flag_r <= 1'b1;
        arm_r <= 1'b0;
      end else if (dma_mode) begin
        if (low_access) flag_r <= 1'b0;
        arm_r <= 1'b0;
      end else if (rd_go && idx == ch_index(k, 0) && flag_r) begin
        arm_r <= 1'b1;
      end else if (wr_go && idx == ch_index(k, 0)) begin
        if (arm_r && !wd[timer_pkg::CH_FLAG]) flag_r <= 1'b0;
        arm_r <= 1'b0;
      end
    end

    always_ff @(posedge clk) begin
      if (!reset_n) begin
        irq_r <= 1'b0;
        dma_r <= 1'b0;
      end else begin
        irq_r <= flag_r & ctl_r[timer_pkg::CH_IE] & ~route_r[k];
        dma_r <= flag_r & dma_mode;
      end
    end

    assign ctl_rd[k] = {flag_r, ctl_r[6:0]};
    assign val_rd[k] = val_r;
    assign ch_irq[k] = irq_r;
    assign ch_dma_req[k] = dma_r;
    assign ch_pin_out[k] = chif[k].pin_out;
    assign ch_pin_oe[k] = chif[k].pin_oe;
  end
endmodule

// ===== dv/timer_counter_control_asserts.sv
// port-level assertion checker for the timer block
module timer_counter_control_asserts #(
  parameter int NUM_CH = 6
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ext_clk_input_force,
  input wire logic [NUM_CH-1:0] ch_pin_oe,
  input wire logic overflow_irq,
  input wire logic [NUM_CH-1:0] ch_irq,
  input wire logic [NUM_CH-1:0] ch_dma_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic setup;
  logic wr_ok;
  logic wr_st;
  logic bad_addr;
  logic ps_ext;
  assign setup = psel && !penable && !pready;
  assign wr_ok = psel && penable && pready && pwrite && pstrb[0];
  assign wr_st = wr_ok && paddr == 8'h80;
  assign bad_addr = paddr[1:0] != 2'h0 || paddr < 8'h80 || paddr > 8'hdc;
  assign ps_ext = pwdata[2:0] == 3'h7;
  AST_ANSWER: assert property (setup |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  AST_UNMAPPED: assert property (setup && !pwrite && bad_addr
    |=> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  AST_MAPPED: assert property (setup && !bad_addr |=> !pslverr)
    else $error("mapped access refused");
  AST_HOLD: assert property (!setup |=> $stable(prdata))
    else $error("read data changed outside setup");
  AST_STATUS_RD: assert property (setup && !pwrite && paddr == 8'h80
    |=> prdata[31:8] == 24'h0 && prdata[4:3] == 2'h0)
    else $error("status clear bit not reading zero");
  AST_ODD_NO_BUF: assert property (setup && !pwrite
    && paddr inside {8'ha4, 8'hbc, 8'hd4} |=> prdata[5] == 1'b0)
    else $error("odd channel shows buffered bit");
  AST_ROUTE_EXCL: assert property ((ch_irq & ch_dma_req) == '0)
    else $error("channel raises irq and dma together");
  AST_SRC_PIN: assert property (wr_st
    |-> ##2 ext_clk_input_force == $past(ps_ext, 2))
    else $error("pin input force does not follow divider field");
  AST_IRQ_MASK: assert property (wr_st && !pwdata[6]
    |-> ##2 !overflow_irq)
    else $error("overflow irq with enable cleared");
  AST_PRESET_OE: assert property (wr_ok && paddr == 8'h98
    && pwdata[3:2] == 2'h0 |-> ##2 !ch_pin_oe[0])
    else $error("channel drives pin in port mode");
  cover property (wr_st && pwdata[4]);
  cover property (overflow_irq);
  cover property (setup && bad_addr);
  cover property (ch_dma_req[0]);
endmodule

bind timer_counter_control timer_counter_control_asserts #(
  .NUM_CH(NUM_CH)
) i_chk (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_clk_input_force(ext_clk_input_force), .ch_pin_oe(ch_pin_oe),
  .overflow_irq(overflow_irq), .ch_irq(ch_irq), .ch_dma_req(ch_dma_req)
);

// ===== dv/tb_timer_counter_control.sv
// self-checking bench for the timer block
module tb_timer_counter_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic reset_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_pin;
  logic [5:0] pin_in;
  logic force_in;
  logic [5:0] pin_out;
  logic [5:0] pin_oe;
  logic ovf_irq;
  logic [5:0] ch_irq;
  logic [5:0] ch_dma;
  logic [31:0] rd;
  logic err;
  logic [15:0] cnt;
  int fail_count;
  int check_count;
  logic [7:0] ra [9] = '{8'h80, 8'h84, 8'h88, 8'h8c, 8'h90, 8'h94,
    8'h98, 8'ha4, 8'hb0};
  logic [7:0] rv [9] = '{8'h20, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff,
    8'h00, 8'h00, 8'h00};

  timer_counter_control i_dut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_clock_pin(ext_pin), .ext_clk_input_force(force_in),
    .ch_pin_in(pin_in), .ch_pin_out(pin_out), .ch_pin_oe(pin_oe),
    .overflow_irq(ovf_irq), .ch_irq(ch_irq), .ch_dma_req(ch_dma)
  );

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // one apb transfer, then an idle cycle so drives never collide
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      $display("Error at %0t: no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 4'h1);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00, 4'h0);
    chk(rd, {24'h0, e});
  endtask

  task automatic rdcnt;
    xfer(1'b0, 8'h88, 8'h00, 4'h0);
    cnt[15:8] = rd[7:0];
    xfer(1'b0, 8'h8c, 8'h00, 4'h0);
    cnt[7:0] = rd[7:0];
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    ext_pin = 1'b0;
    pin_in = 6'h00;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    foreach (ra[i]) rdchk(ra[i], rv[i]);
    chk({25'h0, ovf_irq, pin_oe | ch_irq | ch_dma}, 32'h0);
    chk({26'h0, pin_out}, 32'h3f);
    $display("test reset values done");
    wr(8'h90, 8'h00);
    wr(8'h94, 8'h10);
    wr(8'h80, 8'h00);
    repeat (40) @(posedge clk);
    wr(8'h80, 8'h20);
    rdchk(8'h80, 8'ha0);
    rdcnt();
    chk(32'(cnt <= 16'h0010), 32'h1);
    wr(8'h80, 8'h00);
    repeat (40) @(posedge clk);
    xfer(1'b0, 8'h80, 8'h00, 4'h0);
    repeat (40) @(posedge clk);
    wr(8'h80, 8'h20);
    rdchk(8'h80, 8'ha0);
    wr(8'h80, 8'ha0);
    rdchk(8'h80, 8'ha0);
    wr(8'h80, 8'h20);
    rdchk(8'h80, 8'h20);
    $display("test overflow flag done");
    wr(8'h80, 8'h30);
    wr(8'h88, 8'h55);
    wr(8'h8c, 8'h55);
    repeat (20) @(posedge clk);
    rdcnt();
    chk({16'h0, cnt}, 32'h0);
    rdchk(8'h80, 8'h20);
    $display("test halt and clear done");
    wr(8'h80, 8'h40); // counter left running while irq is awaited
    repeat (40) @(posedge clk);
    chk({31'h0, ovf_irq}, 32'h1);
    wr(8'h80, 8'h60);
    xfer(1'b0, 8'h80, 8'h00, 4'h0);
    wr(8'h80, 8'h60);
    repeat (2) @(posedge clk);
    chk({31'h0, ovf_irq}, 32'h0);
    wr(8'h80, 8'h70);
    wr(8'h90, 8'h00);
    wr(8'h80, 8'h40);
    repeat (60) @(posedge clk);
    chk({31'h0, ovf_irq}, 32'h0);
    wr(8'h80, 8'h60);
    rdchk(8'h80, 8'h60);
    wr(8'h94, 8'h10);
    wr(8'h80, 8'h40);
    repeat (40) @(posedge clk);
    chk({31'h0, ovf_irq}, 32'h1);
    wr(8'h80, 8'h60);
    xfer(1'b0, 8'h80, 8'h00, 4'h0);
    wr(8'h80, 8'h20);
    $display("test interrupt and limit done");
    wr(8'h90, 8'hff);
    wr(8'h94, 8'hff);
    wr(8'h80, 8'h10);
    xfer(1'b0, 8'h88, 8'h00, 4'h0);
    repeat (100) @(posedge clk);
    xfer(1'b0, 8'h88, 8'h00, 4'h0);
    xfer(1'b0, 8'h8c, 8'h00, 4'h0);
    chk(32'(rd[7:0] < 8'h10), 32'h1);
    xfer(1'b0, 8'h8c, 8'h00, 4'h0);
    chk(32'(rd[7:0] > 8'h60), 32'h1);
    $display("test count latch done");
    for (int k = 0; k < 7; k++) begin
      wr(8'h80, 8'h30 | 8'(k));
      wr(8'h80, 8'(k));
      repeat (128) @(posedge clk);
      wr(8'h80, 8'h20 | 8'(k));
      rdcnt();
      chk(32'(cnt + 2 >= 131 >> k && cnt <= (131 >> k) + 2), 32'h1);
    end
    wr(8'h80, 8'h37);
    repeat (2) @(posedge clk);
    chk({31'h0, force_in}, 32'h1);
    wr(8'h80, 8'h07);
    repeat (5) begin
      ext_pin <= 1'b1;
      repeat (4) @(posedge clk);
      ext_pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
    wr(8'h80, 8'h27);
    rdcnt();
    chk({16'h0, cnt}, 32'h5);
    wr(8'h80, 8'h20);
    repeat (2) @(posedge clk);
    chk({31'h0, force_in}, 32'h0);
    $display("test clock source done");
    wr(8'h84, 8'h3f);
    xfer(1'b1, 8'h84, 8'h00, 4'h0);
    rdchk(8'h84, 8'h3f);
    wr(8'h84, 8'h00);
    wr(8'h98, 8'h7f);
    rdchk(8'h98, 8'h7f);
    wr(8'h98, 8'h00);
    wr(8'ha4, 8'h7f);
    rdchk(8'ha4, 8'h5f);
    wr(8'ha4, 8'h00);
    wr(8'hb0, 8'hdf);
    rdchk(8'hb0, 8'h5f);
    wr(8'hb0, 8'h00);
    wr(8'h98, 8'h18);
    repeat (2) @(posedge clk);
    chk({31'h0, pin_oe[0]}, 32'h1);
    wr(8'h98, 8'h00);
    repeat (2) @(posedge clk);
    chk({31'h0, pin_oe[0]}, 32'h0);
    $display("test route and channels done");
    wr(8'h84, 8'h01);
    wr(8'h98, 8'h44);
    pin_in <= 6'h01;
    repeat (3) @(posedge clk);
    chk({20'h0, ch_irq, ch_dma}, 32'h1);
    xfer(1'b0, 8'ha0, 8'h00, 4'h0);
    repeat (2) @(posedge clk);
    chk({20'h0, ch_irq, ch_dma}, 32'h0);
    wr(8'h84, 8'h00);
    pin_in <= 6'h00;
    repeat (2) @(posedge clk);
    pin_in <= 6'h01;
    repeat (3) @(posedge clk);
    chk({20'h0, ch_irq, ch_dma}, 32'h40);
    rdchk(8'h98, 8'hc4);
    wr(8'h98, 8'h44);
    repeat (2) @(posedge clk);
    chk({20'h0, ch_irq, ch_dma}, 32'h0);
    wr(8'h98, 8'h00);
    $display("test capture and requests done");
    wr(8'h80, 8'h30);
    wr(8'h90, 8'h00);
    wr(8'h94, 8'h10);
    wr(8'h9c, 8'h00);
    wr(8'ha0, 8'h10);
    wr(8'h98, 8'h10);
    repeat (2) @(posedge clk);
    chk({31'h0, pin_out[0]}, 32'h0);
    wr(8'h98, 8'h1a);
    wr(8'h80, 8'h00);
    repeat (20) @(posedge clk);
    wr(8'h80, 8'h30);
    chk({31'h0, pin_out[0]}, 32'h1);
    wr(8'h98, 8'h1d);
    wr(8'h80, 8'h00);
    repeat (20) @(posedge clk);
    wr(8'h80, 8'h30);
    chk({31'h0, pin_out[0]}, 32'h0);
    wr(8'h98, 8'h00);
    xfer(1'b0, 8'h80, 8'h00, 4'h0);
    wr(8'h80, 8'h20);
    $display("test compare output done");
    xfer(1'b0, 8'h00, 8'h00, 4'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    xfer(1'b1, 8'h81, 8'h3f, 4'h1);
    chk({31'h0, err}, 32'h1);
    rdchk(8'h80, 8'h20);
    $display("test refused access done");
    tally_and_finish();
  end
endmodule
